/* sct_sdram_core.sv */
// Device-side command and data timing of a four-bank SDR SDRAM.
// Assumes the controller drives all inputs from the same core_clk, so no
// input is synchronised, and that it keeps its own spacing constraints.
`timescale 1ns/1ps
`default_nettype none

module sct_sdram_core #(
   parameter int DATA_W = 16,
   parameter int BANK_W = 2,
   parameter int COL_W = 4,
   parameter int ADDR_W = 13
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W/8-1:0] dqm,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic [DATA_W/8-1:0] dq_oe,
   output logic clock_gated
);

   localparam int BYTES = DATA_W / 8;
   localparam int IDX_W = BANK_W + COL_W;
   localparam int DEPTH = 2 ** IDX_W;
   localparam int REM_W = COL_W + 1;
   localparam int PIPE = 3;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (DATA_W % 8 != 0 || DATA_W < 8) begin : g_bad_width
      $error("DATA_W must be a positive multiple of 8");
   end
   if (COL_W < 1 || COL_W > ADDR_W - 1 || ADDR_W <= sct_pkg::ALL_BANKS_BIT)
   begin : g_bad_addr
      $error("COL_W or ADDR_W out of range");
   end

   // -----------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------
   function automatic sct_pkg::sct_cmd_t decode_cmd(
      input logic sel_n, input logic r_n, input logic c_n, input logic w_n);
      if (sel_n) begin
         return sct_pkg::SCT_CMD_NOP;
      end
      return sct_pkg::sct_cmd_t'({r_n, c_n, w_n});
   endfunction : decode_cmd

   function automatic logic [REM_W-1:0] burst_words(input logic [2:0] code);
      case (code)
         sct_pkg::BL_CODE_2: return REM_W'(2);
         sct_pkg::BL_CODE_4: return REM_W'(4);
         sct_pkg::BL_CODE_8: return REM_W'(8);
         sct_pkg::BL_CODE_PAGE: return REM_W'(2 ** COL_W);
         default: return REM_W'(1);
      endcase
   endfunction : burst_words

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic cke_q, cke_d;
   sct_pkg::sct_state_t state_q, state_d;
   logic [REM_W-1:0] rem_q, rem_d;
   logic [COL_W-1:0] col_q, col_d;
   logic [BANK_W-1:0] bank_q, bank_d;
   logic [2:0] bl_code_q, bl_code_d;
   logic lat3_q, lat3_d;
   logic [DATA_W-1:0] mem_q [DEPTH];
   logic [DATA_W-1:0] mem_d [DEPTH];
   logic [PIPE-1:0] pv_q, pv_d;
   logic [DATA_W-1:0] pd_q [PIPE];
   logic [DATA_W-1:0] pd_d [PIPE];
   logic [BYTES-1:0] mask_q [sct_pkg::READ_MASK_TURNOFF_LATENCY];
   logic [BYTES-1:0] mask_d [sct_pkg::READ_MASK_TURNOFF_LATENCY];

   sct_pkg::sct_cmd_t cmd;
   logic run;
   logic word_en;
   logic word_wr;
   logic [COL_W-1:0] word_col;
   logic [BANK_W-1:0] word_bank;
   logic [IDX_W-1:0] word_idx;
   logic [REM_W-1:0] bl_words;

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      cmd = decode_cmd(cs_n, ras_n, cas_n, we_n);
      // The gate sampled on the previous edge decides this edge.
      run = cke_q;
      cke_d = cke;
      state_d = state_q;
      rem_d = rem_q;
      col_d = col_q;
      bank_d = bank_q;
      bl_code_d = bl_code_q;
      lat3_d = lat3_q;
      mem_d = mem_q;
      pv_d = pv_q;
      pd_d = pd_q;
      mask_d = mask_q;
      word_en = 1'b0;
      word_wr = 1'b0;
      word_col = col_q;
      word_bank = bank_q;
      bl_words = burst_words(bl_code_q);
      if (run) begin
         case (cmd)
            sct_pkg::SCT_CMD_READ, sct_pkg::SCT_CMD_WRITE: begin
               // A column command always wins over a running burst.
               word_en = 1'b1;
               word_wr = (cmd == sct_pkg::SCT_CMD_WRITE);
               word_col = addr[COL_W-1:0];
               word_bank = ba;
               rem_d = REM_W'(bl_words - REM_W'(1));
               if (bl_words == REM_W'(1)) begin
                  state_d = sct_pkg::SCT_ST_IDLE;
               end else if (word_wr) begin
                  state_d = sct_pkg::SCT_ST_WRITE;
               end else begin
                  state_d = sct_pkg::SCT_ST_READ;
               end
            end
            sct_pkg::SCT_CMD_BURST_STOP: begin
               state_d = sct_pkg::SCT_ST_IDLE;
            end
            sct_pkg::SCT_CMD_PRECHARGE: begin
               // Closing the burst's bank or all banks fetches no word on this edge, so the output floats
               // exactly one read latency later.
               if (addr[sct_pkg::ALL_BANKS_BIT] || ba == bank_q) begin
                  state_d = sct_pkg::SCT_ST_IDLE;
               end
            end
            sct_pkg::SCT_CMD_LOAD_MODE: begin
               if (ba == '0) begin
                  bl_code_d = addr[sct_pkg::MODE_BL_LSB +: sct_pkg::MODE_BL_W];
                  case (addr[sct_pkg::MODE_LAT_LSB +: sct_pkg::MODE_LAT_W])
                     sct_pkg::LAT_CODE_2: lat3_d = 1'b0;
                     sct_pkg::LAT_CODE_3: lat3_d = 1'b1;
                     default: lat3_d = lat3_q;
                  endcase
               end
            end
            default: begin
            end
         endcase
         if (!word_en && state_d != sct_pkg::SCT_ST_IDLE) begin
            word_en = 1'b1;
            word_wr = (state_q == sct_pkg::SCT_ST_WRITE);
            rem_d = REM_W'(rem_q - REM_W'(1));
            if (rem_q == REM_W'(1)) begin
               state_d = sct_pkg::SCT_ST_IDLE;
            end
         end
         if (word_en) begin
            col_d = COL_W'(word_col + COL_W'(1));
            bank_d = word_bank;
         end
      end
      word_idx = {word_bank, word_col};
      if (run) begin
         for (int b = 0; b < BYTES; b++) begin
            // Data and mask are both taken on the command's own edge.
            if (word_en && word_wr && !dqm[b]) begin
               mem_d[word_idx][b*8 +: 8] = dq_in[b*8 +: 8];
            end
         end
         pv_d[0] = word_en && !word_wr;
         pd_d[0] = mem_q[word_idx];
         for (int i = 1; i < PIPE; i++) begin
            pv_d[i] = pv_q[i-1];
            pd_d[i] = pd_q[i-1];
         end
         mask_d[0] = dqm;
         for (int i = 1; i < sct_pkg::READ_MASK_TURNOFF_LATENCY; i++) begin
            mask_d[i] = mask_q[i-1];
         end
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cke_q <= 1'b0;
         state_q <= sct_pkg::SCT_ST_IDLE;
         rem_q <= '0;
         col_q <= '0;
         bank_q <= '0;
         bl_code_q <= sct_pkg::RESET_BL_CODE;
         lat3_q <= sct_pkg::RESET_LAT3;
         pv_q <= '0;
         for (int i = 0; i < PIPE; i++) begin
            pd_q[i] <= '0;
         end
         for (int i = 0; i < sct_pkg::READ_MASK_TURNOFF_LATENCY; i++) begin
            mask_q[i] <= '0;
         end
      end else begin
         cke_q <= cke_d;
         state_q <= state_d;
         rem_q <= rem_d;
         col_q <= col_d;
         bank_q <= bank_d;
         bl_code_q <= bl_code_d;
         lat3_q <= lat3_d;
         pv_q <= pv_d;
         pd_q <= pd_d;
         mask_q <= mask_d;
      end
   end

   // Array contents are left unreset, as in a real cell array.
   always_ff @(posedge core_clk) begin
      mem_q <= mem_d;
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Stage 1 is seen at latency 2, stage 2 at latency 3.
   assign dq_out = lat3_q ? pd_q[2] : pd_q[1];
   assign dq_oe = {BYTES{lat3_q ? pv_q[2] : pv_q[1]}} &
      ~mask_q[sct_pkg::READ_MASK_TURNOFF_LATENCY-1];
   assign clock_gated = ~cke_q;

endmodule : sct_sdram_core

`default_nettype wire

/* sct_pkg.sv */
// Constants, command and state encodings of the SDRAM command-timing core.
// Assumes one system clock shared with the memory controller.
package sct_pkg;

   // -----------------------------------------------------------------
   // Latencies in clock cycles
   // -----------------------------------------------------------------
   localparam int GATE_LOW_LATENCY = 1;
   localparam int GATE_HIGH_LATENCY = 1;
   localparam int WRITE_DATA_DELAY = 0;
   localparam int WRITE_MASK_LATENCY = 0;
   localparam int READ_MASK_TURNOFF_LATENCY = 2;
   localparam int COLUMN_TO_COLUMN_GAP = 1;

   // -----------------------------------------------------------------
   // Mode word layout and reset values
   // -----------------------------------------------------------------
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BL_W = 3;
   localparam int MODE_LAT_LSB = 4;
   localparam int MODE_LAT_W = 3;
   localparam logic [2:0] BL_CODE_1 = 3'h0;
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_PAGE = 3'h7;
   localparam logic [2:0] LAT_CODE_2 = 3'h2;
   localparam logic [2:0] LAT_CODE_3 = 3'h3;
   localparam logic [2:0] RESET_BL_CODE = 3'h0;
   localparam logic RESET_LAT3 = 1'b1;
   localparam int ALL_BANKS_BIT = 10;

   // -----------------------------------------------------------------
   // Commands as {ras_n, cas_n, we_n}
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCT_CMD_LOAD_MODE = 3'h0,
      SCT_CMD_REFRESH = 3'h1,
      SCT_CMD_PRECHARGE = 3'h2,
      SCT_CMD_ACTIVE = 3'h3,
      SCT_CMD_WRITE = 3'h4,
      SCT_CMD_READ = 3'h5,
      SCT_CMD_BURST_STOP = 3'h6,
      SCT_CMD_NOP = 3'h7
   } sct_cmd_t;

   typedef enum logic [1:0] {
      SCT_ST_IDLE = 2'h0,
      SCT_ST_READ = 2'h1,
      SCT_ST_WRITE = 2'h3
   } sct_state_t;

endpackage : sct_pkg

/* sct_props.sv */
// Port checker for the SDRAM command-timing core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sct_chk #(
   parameter int DATA_W = 16,
   parameter int BANK_W = 2,
   parameter int COL_W = 4,
   parameter int ADDR_W = 13
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W/8-1:0] dqm,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic [DATA_W/8-1:0] dq_oe,
   input wire logic clock_gated
);
   logic lat3_q;
   logic lat3_d;
   logic act;
   logic [2:0] op;
   assign act = !clock_gated && !cs_n;
   assign op = {ras_n, cas_n, we_n};
   // Latency is tracked so the turn-on and turn-off figures can be exact.
   always_comb begin
      lat3_d = lat3_q;
      if (act && op == 3'h0 && ba == '0 && addr[6:5] == 2'h1) begin
         lat3_d = addr[4];
      end
   end
   always_ff @(posedge core_clk) begin
      lat3_q <= rst ? sct_pkg::RESET_LAT3 : lat3_d;
   end
   a_gate_low: assert property (@(posedge core_clk) disable iff (rst)
      !cke |=> clock_gated) else $error("gate did not close");
   a_gate_high: assert property (@(posedge core_clk) disable iff (rst)
      cke |=> !clock_gated) else $error("gate did not open");
   a_gate_frozen: assert property (@(posedge core_clk) disable iff (rst)
      clock_gated |=> $stable(dq_oe) && $stable(dq_out))
      else $error("outputs moved while gated");
   a_read_lat3: assert property (@(posedge core_clk) disable iff (rst)
      act && op == 3'h5 && lat3_q && cke && dqm == '0 ##1 cke && dqm == '0
      |-> ##2 &dq_oe) else $error("read word missing at latency 3");
   a_read_lat2: assert property (@(posedge core_clk) disable iff (rst)
      act && op == 3'h5 && !lat3_q && cke && dqm == '0 |-> ##2 &dq_oe)
      else $error("read word missing at latency 2");
   a_mask_read: assert property (@(posedge core_clk) disable iff (rst)
      !clock_gated && cke && dqm != '0 |-> ##2 (dq_oe & $past(dqm, 2)) == '0)
      else $error("masked byte still driven");
   a_pre_off3: assert property (@(posedge core_clk) disable iff (rst)
      act && op == 3'h2 && addr[10] && lat3_q && cke ##1 cke
      |-> ##2 dq_oe == '0) else $error("outputs on after precharge");
   a_pre_off2: assert property (@(posedge core_clk) disable iff (rst)
      act && op == 3'h2 && addr[10] && !lat3_q && cke |-> ##2 dq_oe == '0)
      else $error("outputs on after precharge");
endmodule : sct_chk
bind sct_sdram_core sct_chk #(.DATA_W(DATA_W), .BANK_W(BANK_W),
   .COL_W(COL_W), .ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk), .rst(rst),
   .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
   .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
   .dq_oe(dq_oe), .clock_gated(clock_gated));
`default_nettype wire

/* sct_ctl_model.sv */
// Memory controller model driving commands, masks and write data.
// Assumes the core samples all inputs on the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module sct_ctl_model (
   input wire logic core_clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output logic [12:0] addr,
   output logic [1:0] dqm,
   output logic [15:0] dq_in
);
   initial begin
      cke = 1'b0;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      ba = 2'h0;
      addr = 13'h0000;
      dqm = 2'h0;
      dq_in = 16'h0000;
   end
   // Fields left out of a call default to bank 0, address 0, no mask.
   task automatic issue(input sct_pkg::sct_cmd_t c, input logic [1:0] b = 2'h0,
      input logic [12:0] a = 13'h0000, input logic [1:0] m = 2'h0,
      input logic [15:0] d = 16'h0000);
      @(posedge core_clk);
      #1;
      cs_n = 1'b0;
      {ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      dqm = m;
      dq_in = d;
   endtask : issue
   // Released data lines invert each idle cycle, so a stale word passes as written only after an even number of them.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
         cs_n = 1'b1;
         {ras_n, cas_n, we_n} = 3'h7;
         dqm = 2'h0;
         dq_in = ~dq_in;
      end
   endtask : idle
   task automatic gate(input logic v);
      @(posedge core_clk);
      #1;
      cke = v;
      cs_n = 1'b1;
   endtask : gate
endmodule : sct_ctl_model
`default_nettype wire

/* tb_sdram_command_timing.sv */
// Self-checking bench for the SDRAM command-timing core.
// Assumes the controller model drives every core input except core_clk and rst.
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_command_timing;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cke, cs_n, ras_n, cas_n, we_n, clock_gated;
   logic [1:0] ba, dqm, dq_oe;
   logic [12:0] addr;
   logic [15:0] dq_in, dq_out;
   int errors = 0;
   int total_checks = 0;
   typedef struct {logic [1:0] b; logic [12:0] c; logic [15:0] d1, d2;
      logic [1:0] m; logic [15:0] e;} sct_row_t;
   sct_row_t rows [4] = '{'{2'h0, 13'h0000, 16'h1234, 16'hABCD, 2'h0, 16'hABCD},
      '{2'h1, 13'h0005, 16'h1234, 16'hABCD, 2'h1, 16'hAB34},
      '{2'h2, 13'h000A, 16'h5A5A, 16'hC3C3, 2'h2, 16'h5AC3},
      '{2'h3, 13'h000F, 16'h0F0F, 16'hF0F0, 2'h3, 16'h0F0F}};
   sct_ctl_model u_ctl (.core_clk(core_clk), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
      .dqm(dqm), .dq_in(dq_in));
   sct_sdram_core dut (.core_clk(core_clk), .rst(rst), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .clock_gated(clock_gated));
   always #2.5 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #100us;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (9) @(posedge core_clk);
      u_ctl.gate(1'b1);
      rst = 1'b0;
      u_ctl.issue(sct_pkg::SCT_CMD_ACTIVE);
      u_ctl.idle(4);
      u_ctl.issue(sct_pkg::SCT_CMD_REFRESH);
      u_ctl.idle(15);
      foreach (rows[i]) begin
         u_ctl.issue(sct_pkg::SCT_CMD_WRITE, rows[i].b, rows[i].c, 2'h0,
            rows[i].d1);
         u_ctl.issue(sct_pkg::SCT_CMD_WRITE, rows[i].b, rows[i].c, rows[i].m,
            rows[i].d2);
         u_ctl.issue(sct_pkg::SCT_CMD_READ, rows[i].b, rows[i].c);
         u_ctl.idle(3);
         chk("oe", 16'h0003, dq_oe);
         chk("data", rows[i].e, dq_out);
      end
      u_ctl.issue(sct_pkg::SCT_CMD_LOAD_MODE, 2'h0, 13'h0021);
      u_ctl.idle(2);
      u_ctl.issue(sct_pkg::SCT_CMD_READ, 2'h1, 13'h0005);
      u_ctl.issue(sct_pkg::SCT_CMD_NOP, 2'h0, 13'h0000, 2'h2);
      u_ctl.idle(1);
      chk("lat2 oe", 16'h0003, dq_oe);
      chk("lat2 data", 16'hAB34, dq_out);
      u_ctl.idle(1);
      chk("mask oe", 16'h0001, dq_oe);
      u_ctl.idle(1);
      chk("burst end oe", 16'h0000, dq_oe);
      // Without the precharge the second word would still be driven.
      u_ctl.issue(sct_pkg::SCT_CMD_READ, 2'h1, 13'h0005);
      u_ctl.issue(sct_pkg::SCT_CMD_PRECHARGE, 2'h0, 13'h0400);
      u_ctl.idle(1);
      chk("lat2 last word oe", 16'h0003, dq_oe);
      u_ctl.idle(1);
      chk("lat2 pre off oe", 16'h0000, dq_oe);
      u_ctl.issue(sct_pkg::SCT_CMD_LOAD_MODE, 2'h0, 13'h0033);
      u_ctl.idle(2);
      u_ctl.issue(sct_pkg::SCT_CMD_READ, 2'h2, 13'h000A);
      u_ctl.issue(sct_pkg::SCT_CMD_PRECHARGE, 2'h0, 13'h0400);
      u_ctl.idle(2);
      chk("last word oe", 16'h0003, dq_oe);
      u_ctl.idle(1);
      chk("pre off oe", 16'h0000, dq_oe);
      u_ctl.idle(3);
      u_ctl.issue(sct_pkg::SCT_CMD_READ);
      u_ctl.gate(1'b0);
      u_ctl.idle(1);
      chk("gated", 16'h0001, {15'h0, clock_gated});
      u_ctl.idle(3);
      chk("frozen oe", 16'h0000, dq_oe);
      u_ctl.gate(1'b1);
      u_ctl.idle(1);
      chk("ungated", 16'h0000, {15'h0, clock_gated});
      u_ctl.idle(1);
      chk("resumed oe", 16'h0003, dq_oe);
      chk("resumed data", 16'hABCD, dq_out);
      u_ctl.issue(sct_pkg::SCT_CMD_BURST_STOP);
      u_ctl.idle(4);
      u_ctl.issue(sct_pkg::SCT_CMD_READ);
      u_ctl.idle(3);
      rst = 1'b1;
      u_ctl.idle(1);
      chk("reset oe", 16'h0000, dq_oe);
      chk("reset data", 16'h0000, dq_out);
      chk("reset gate", 16'h0001, {15'h0, clock_gated});
      tally_and_finish();
   end
endmodule : tb_sdram_command_timing
`default_nettype wire
